// *** verilog/adr_pkg.sv ***
package adr_pkg;
	// Bus widths and bank counts
	localparam int ADR_ADDR_W = 10;
	localparam int ADR_DATA_W = 8;
	localparam int ADR_IDX_W = 4;
	localparam int ADR_NUM_REGS = 9;
	localparam int ADR_NUM_CHAN = 5;
	localparam int ADR_MEAS_W = 16;

	// Register offsets
	localparam logic [9:0] ADR_UT_REF_HIGH = 10'h245;
	localparam logic [9:0] ADR_UT_REF_LOW = 10'h246;
	localparam logic [9:0] ADR_THERMAL_WARNING_CUR_HIGH = 10'h247;
	localparam logic [9:0] ADR_THERMAL_WARNING_CUR_LOW = 10'h248;
	localparam logic [9:0] ADR_CORE_SUP_HIGH = 10'h249;
	localparam logic [9:0] ADR_CORE_SUP_LOW = 10'h24A;
	localparam logic [9:0] ADR_TBIAS_HIGH = 10'h24B;
	localparam logic [9:0] ADR_TBIAS_LOW = 10'h24C;
	localparam logic [9:0] ADR_COMM_SUP_HIGH = 10'h24D;
	localparam logic [9:0] ADR_BANK_FIRST = ADR_UT_REF_HIGH;
	localparam logic [9:0] ADR_BANK_LAST = ADR_COMM_SUP_HIGH;

	// Reset values and idle read value
	localparam logic [7:0] ADR_HIGH_RESET = 8'h80;
	localparam logic [7:0] ADR_LOW_RESET = 8'h00;
	localparam logic [7:0] ADR_RDATA_IDLE = 8'h00;

	// Measurement channels of the converter
	typedef enum logic [2:0] {
		ADR_CH_UT_REF = 3'h0,
		ADR_CH_THERMAL_WARNING_CUR = 3'h1,
		ADR_CH_CORE_SUP = 3'h2,
		ADR_CH_TBIAS = 3'h3,
		ADR_CH_COMM_SUP = 3'h4
	} adr_chan_t;

	// Address lies inside the bank
	function automatic logic adr_in_bank(logic [9:0] a);
		return (a >= ADR_BANK_FIRST) && (a <= ADR_BANK_LAST);
	endfunction : adr_in_bank

	// Bank slot of an address
	function automatic logic [3:0] adr_index(logic [9:0] a);
		logic [9:0] d;
		d = a - ADR_BANK_FIRST;
		return d[3:0];
	endfunction : adr_index

	// Even slots hold upper bytes
	function automatic logic adr_is_high(logic [3:0] i);
		return ~i[0];
	endfunction : adr_is_high

	// Reset value of a slot
	function automatic logic [7:0] adr_reset_value(logic [3:0] i);
		return adr_is_high(i) ? ADR_HIGH_RESET : ADR_LOW_RESET;
	endfunction : adr_reset_value

	// Slot of a channel's upper byte
	function automatic logic [3:0] adr_chan_high(adr_chan_t c);
		return {c, 1'b0};
	endfunction : adr_chan_high

	// Known channel code
	function automatic logic adr_chan_ok(adr_chan_t c);
		return c <= ADR_CH_COMM_SUP;
	endfunction : adr_chan_ok

	// Channel whose lower byte lives in this bank
	function automatic logic adr_chan_has_low(adr_chan_t c);
		return c != ADR_CH_COMM_SUP;
	endfunction : adr_chan_has_low
endpackage : adr_pkg

// *** verilog/adr_rd_if.sv ***
interface adr_rd_if;
	import adr_pkg::*;
	logic [3:0] idx;
	logic hit;
	logic rd_take;
	logic wr_take;
	logic [7:0] sel_data;

	// Bus port decodes, core answers with the selected byte
	modport port (output idx, output hit, output rd_take, output wr_take, input sel_data);
	modport core (input idx, input hit, input rd_take, input wr_take, output sel_data);
endinterface : adr_rd_if

// *** verilog/adr_bus_port.sv ***
module adr_bus_port (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [adr_pkg::ADR_ADDR_W-1:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [adr_pkg::ADR_DATA_W-1:0] reg_rdata_out,
	output logic unmapped_out,
	adr_rd_if.port bus
);
	import adr_pkg::*;

	// Address decode
	always_comb begin
		bus.hit = adr_in_bank(reg_addr_in);
		bus.idx = adr_index(reg_addr_in);
		bus.rd_take = reg_rd_in;
		bus.wr_take = reg_wr_in;
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= ADR_RDATA_IDLE;
		end else if (reg_rd_in && bus.hit) begin
			reg_rdata_out <= bus.sel_data;
		end else begin
			reg_rdata_out <= ADR_RDATA_IDLE;
		end
	end

	// Access outside the bank flags for one cycle
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			unmapped_out <= 1'b0;
		end else begin
			unmapped_out <= (reg_rd_in || reg_wr_in) && !bus.hit;
		end
	end

	// Idle read data between reads
	property p_rdata_idle;
		@(posedge core_clk_in) disable iff (rst_in)
		!reg_rd_in |=> reg_rdata_out == ADR_RDATA_IDLE;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

	// Unmapped access answers with idle data and a flag
	property p_unmapped;
		@(posedge core_clk_in) disable iff (rst_in)
		reg_rd_in && !adr_in_bank(reg_addr_in)
			|=> unmapped_out && reg_rdata_out == ADR_RDATA_IDLE;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read misanswered");
endmodule : adr_bus_port

// *** verilog/adr_readback_bank.sv ***
// Overview of operation
// - Under-temperature reference readback: upper byte 0x245, lower byte 0x246, read-only.
// - Thermal-warning current readback: upper byte 0x247, lower byte 0x248, read-only.
// - Core regulator readback: upper byte 0x249, lower byte 0x24A, read-only.
// - Thermistor bias readback: upper byte 0x24B, lower byte 0x24C, read-only.
// - Comm regulator upper byte readback at 0x24D, read-only.
// - Every lower byte resets to zero.
// - Every upper byte resets with bit 7 set, others clear.
// - Each register is one read-only byte; host writes change nothing.
module adr_readback_bank (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic [adr_pkg::ADR_ADDR_W-1:0] reg_addr_in,
	input wire logic [adr_pkg::ADR_DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [adr_pkg::ADR_DATA_W-1:0] reg_rdata_out,
	input wire logic meas_valid_in,
	input wire adr_pkg::adr_chan_t meas_chan_in,
	input wire logic [adr_pkg::ADR_MEAS_W-1:0] meas_data_in,
	output logic [adr_pkg::ADR_NUM_CHAN-1:0] loaded_out,
	output logic wr_ignored_out,
	output logic unmapped_out
);
	import adr_pkg::*;

	// Package constants must agree with the storage layout
	if (ADR_NUM_REGS != 2 * ADR_NUM_CHAN - 1) begin : g_bad_count
		$error("slot count does not match channel count");
	end
	if (ADR_NUM_REGS > (1 << ADR_IDX_W)) begin : g_bad_idx
		$error("slot index too narrow for the bank");
	end
	if (ADR_MEAS_W != 2 * ADR_DATA_W) begin : g_bad_meas
		$error("result does not split into two bytes");
	end
	if (ADR_BANK_LAST - ADR_BANK_FIRST + 1 != ADR_NUM_REGS) begin : g_bad_span
		$error("address span does not match slot count");
	end

	logic [7:0] bank [ADR_NUM_REGS];
	logic [7:0] next_bank [ADR_NUM_REGS];
	logic [ADR_NUM_REGS*8-1:0] bank_flat;
	logic [31:0] low_flat;
	logic [39:0] high_flat;
	logic [7:0] meas_high;
	logic [ADR_NUM_CHAN-1:0] next_loaded;
	logic [7:0] wdata_seen;

	adr_rd_if rd_bus ();

	// Register port: decode and read data flop
	adr_bus_port u_port (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.reg_addr_in(reg_addr_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out),
		.unmapped_out(unmapped_out),
		.bus(rd_bus.port)
	);

	// Write data never reaches storage
	assign wdata_seen = reg_wdata_in;
	assign meas_high = meas_data_in[15:8];

	// Converter result lands in its byte pair, comm in its upper byte only; host writes are not a source
	always_comb begin
		logic [3:0] h;
		h = adr_chan_high(meas_chan_in);
		for (int i = 0; i < ADR_NUM_REGS; i++) begin
			next_bank[i] = bank[i];
		end
		if (meas_valid_in && adr_chan_ok(meas_chan_in)) begin
			next_bank[h] = meas_data_in[15:8];
			if (adr_chan_has_low(meas_chan_in)) begin
				next_bank[{h[3:1], 1'b1}] = meas_data_in[7:0];
			end
		end
	end

	// Byte storage with per-slot reset values
	always_ff @(posedge core_clk_in) begin
		for (int i = 0; i < ADR_NUM_REGS; i++) begin
			if (rst_in) begin
				bank[i] <= adr_reset_value(4'(i));
			end else begin
				bank[i] <= next_bank[i];
			end
		end
	end

	// Selected byte for a read; reading leaves storage alone
	always_comb begin
		if (rd_bus.hit) begin
			rd_bus.sel_data = bank[rd_bus.idx];
		end else begin
			rd_bus.sel_data = ADR_RDATA_IDLE;
		end
	end

	// Channel has delivered at least one result since reset
	always_comb begin
		next_loaded = loaded_out;
		if (meas_valid_in && adr_chan_ok(meas_chan_in)) begin
			next_loaded[meas_chan_in] = 1'b1;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			loaded_out <= '0;
		end else begin
			loaded_out <= next_loaded;
		end
	end

	// Write that hit a read-only byte, one-cycle flag
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			wr_ignored_out <= 1'b0;
		end else begin
			wr_ignored_out <= rd_bus.wr_take && rd_bus.hit;
		end
	end

	// Flat views for checking
	always_comb begin
		bank_flat = '0;
		low_flat = '0;
		high_flat = '0;
		for (int i = 0; i < ADR_NUM_REGS; i++) begin
			bank_flat[i*8 +: 8] = bank[i];
			if (i % 2 == 0) begin
				high_flat[(i/2)*8 +: 8] = bank[i];
			end else begin
				low_flat[(i/2)*8 +: 8] = bank[i];
			end
		end
	end

	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);

	// Read of a given offset
	sequence s_rd_at(logic [9:0] a);
		reg_rd_in && reg_addr_in == a;
	endsequence

	// Converter update of a given channel
	sequence s_upd(adr_chan_t c);
		meas_valid_in && meas_chan_in == c;
	endsequence

	property p_ut_ref_pair;
		(s_rd_at(ADR_UT_REF_HIGH) |=> reg_rdata_out == $past(bank[0]))
		and (s_rd_at(ADR_UT_REF_LOW) |=> reg_rdata_out == $past(bank[1]))
		and (s_upd(ADR_CH_UT_REF) |=> {bank[0], bank[1]} == $past(meas_data_in));
	endproperty
	a_ut_ref_pair: assert property (p_ut_ref_pair) else $error("ut ref pair wrong");

	property p_thermal_warning_pair;
		(s_rd_at(ADR_THERMAL_WARNING_CUR_HIGH) |=> reg_rdata_out == $past(bank[2]))
		and (s_rd_at(ADR_THERMAL_WARNING_CUR_LOW) |=> reg_rdata_out == $past(bank[3]))
		and (s_upd(ADR_CH_THERMAL_WARNING_CUR) |=> {bank[2], bank[3]} == $past(meas_data_in));
	endproperty
	a_thermal_warning_pair: assert property (p_thermal_warning_pair) else $error("thermal_warning pair wrong");

	property p_core_pair;
		(s_rd_at(ADR_CORE_SUP_HIGH) |=> reg_rdata_out == $past(bank[4]))
		and (s_rd_at(ADR_CORE_SUP_LOW) |=> reg_rdata_out == $past(bank[5]))
		and (s_upd(ADR_CH_CORE_SUP) |=> {bank[4], bank[5]} == $past(meas_data_in));
	endproperty
	a_core_pair: assert property (p_core_pair) else $error("core supply pair wrong");

	property p_bias_pair;
		(s_rd_at(ADR_TBIAS_HIGH) |=> reg_rdata_out == $past(bank[6]))
		and (s_rd_at(ADR_TBIAS_LOW) |=> reg_rdata_out == $past(bank[7]))
		and (s_upd(ADR_CH_TBIAS) |=> {bank[6], bank[7]} == $past(meas_data_in));
	endproperty
	a_bias_pair: assert property (p_bias_pair) else $error("bias pair wrong");

	property p_comm_high;
		(s_rd_at(ADR_COMM_SUP_HIGH) |=> reg_rdata_out == $past(bank[8]))
		and (s_upd(ADR_CH_COMM_SUP) |=> bank[8] == $past(meas_high));
	endproperty
	a_comm_high: assert property (p_comm_high) else $error("comm high wrong");

	property p_low_reset;
		$fell(rst_in) |-> low_flat == {4{ADR_LOW_RESET}};
	endproperty
	a_low_reset: assert property (p_low_reset) else $error("low byte reset wrong");

	property p_high_reset;
		$fell(rst_in) |-> high_flat == {5{ADR_HIGH_RESET}} && loaded_out == '0;
	endproperty
	a_high_reset: assert property (p_high_reset) else $error("high byte reset wrong");

	property p_write_ignored;
		reg_wr_in && adr_in_bank(reg_addr_in) && !meas_valid_in
			|=> $stable(bank_flat) && wr_ignored_out;
	endproperty
	a_write_ignored: assert property (p_write_ignored) else $error("write altered bank");

	property p_read_clean;
		(reg_rd_in && !meas_valid_in) ##1 (reg_rd_in && $stable(reg_addr_in) && !meas_valid_in)
			|=> $stable(reg_rdata_out) && $stable(bank_flat);
	endproperty
	a_read_clean: assert property (p_read_clean) else $error("read had side effect");

	// No converter strobe leaves every byte in place
	property p_hold_idle;
		!meas_valid_in |=> $stable(bank_flat);
	endproperty
	a_hold_idle: assert property (p_hold_idle) else $error("bank moved without update");

	// Unknown channel codes change nothing
	property p_bad_chan;
		meas_valid_in && !adr_chan_ok(meas_chan_in) |=> $stable(bank_flat) && $stable(loaded_out);
	endproperty
	a_bad_chan: assert property (p_bad_chan) else $error("bad channel took effect");

	// Comm result leaves every lower byte alone
	property p_comm_low_dropped;
		s_upd(ADR_CH_COMM_SUP) |=> $stable(low_flat);
	endproperty
	a_comm_low_dropped: assert property (p_comm_low_dropped) else $error("comm low leaked");

	// Loaded flags never drop outside reset
	property p_loaded_sticky;
		!$past(rst_in) |-> (($past(loaded_out) & ~loaded_out) == '0);
	endproperty
	a_loaded_sticky: assert property (p_loaded_sticky) else $error("loaded flag dropped");

	// A good update marks its channel loaded
	property p_loaded_set;
		meas_valid_in && adr_chan_ok(meas_chan_in) |=> loaded_out[$past(meas_chan_in)];
	endproperty
	a_loaded_set: assert property (p_loaded_set) else $error("loaded flag not set");

	// Loaded flags move only on updates
	property p_loaded_quiet;
		!meas_valid_in |=> $stable(loaded_out);
	endproperty
	a_loaded_quiet: assert property (p_loaded_quiet) else $error("loaded flag moved");

	// Dropped-write flag only after an in-bank write
	property p_wr_flag_quiet;
		!(reg_wr_in && adr_in_bank(reg_addr_in)) |=> !wr_ignored_out;
	endproperty
	a_wr_flag_quiet: assert property (p_wr_flag_quiet) else $error("stray dropped-write flag");

	// Write outside the bank flags unmapped only
	property p_unmapped_write;
		reg_wr_in && !adr_in_bank(reg_addr_in)
			|=> unmapped_out && !wr_ignored_out;
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("outside write misflagged");

	// Reads change neither bytes nor loaded flags
	property p_read_keeps;
		reg_rd_in && !meas_valid_in |=> $stable(bank_flat) && $stable(loaded_out);
	endproperty
	a_read_keeps: assert property (p_read_keeps) else $error("read changed state");

	// Each update touches only its own pair, or for comm its upper byte
	property p_ut_others;
		s_upd(ADR_CH_UT_REF) |=> $stable(bank_flat[71:16]);
	endproperty
	a_ut_others: assert property (p_ut_others) else $error("ut update spilled");

	property p_thermal_warning_others;
		s_upd(ADR_CH_THERMAL_WARNING_CUR) |=> $stable({bank_flat[71:32], bank_flat[15:0]});
	endproperty
	a_thermal_warning_others: assert property (p_thermal_warning_others) else $error("thermal_warning update spilled");

	property p_core_others;
		s_upd(ADR_CH_CORE_SUP) |=> $stable({bank_flat[71:48], bank_flat[31:0]});
	endproperty
	a_core_others: assert property (p_core_others) else $error("core update spilled");

	property p_bias_others;
		s_upd(ADR_CH_TBIAS) |=> $stable({bank_flat[71:64], bank_flat[47:0]});
	endproperty
	a_bias_others: assert property (p_bias_others) else $error("bias update spilled");

	property p_comm_others;
		s_upd(ADR_CH_COMM_SUP) |=> $stable(bank_flat[63:0]);
	endproperty
	a_comm_others: assert property (p_comm_others) else $error("comm update spilled");

	// Port outputs are quiet right after reset
	property p_reset_outputs;
		$fell(rst_in) |-> reg_rdata_out == ADR_RDATA_IDLE && !wr_ignored_out && !unmapped_out;
	endproperty
	a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not quiet");

	// In-bank reads never flag unmapped
	property p_read_mapped;
		reg_rd_in && adr_in_bank(reg_addr_in) |=> !unmapped_out;
	endproperty
	a_read_mapped: assert property (p_read_mapped) else $error("bank read flagged");

	// No access, no unmapped flag
	property p_unmapped_quiet;
		!reg_rd_in && !reg_wr_in |=> !unmapped_out;
	endproperty
	a_unmapped_quiet: assert property (p_unmapped_quiet) else $error("stray unmapped flag");

	// Update followed at once by a read of its byte
	sequence s_upd_then_rd(adr_chan_t c, logic [9:0] a);
		s_upd(c) ##1 s_rd_at(a);
	endsequence

	property p_comm_fresh;
		s_upd_then_rd(ADR_CH_COMM_SUP, ADR_COMM_SUP_HIGH)
			|=> reg_rdata_out == $past(meas_high, 2);
	endproperty
	a_comm_fresh: assert property (p_comm_fresh) else $error("comm read stale");

	property p_ut_high_fresh;
		s_upd_then_rd(ADR_CH_UT_REF, ADR_UT_REF_HIGH)
			|=> reg_rdata_out == $past(meas_data_in[15:8], 2);
	endproperty
	a_ut_high_fresh: assert property (p_ut_high_fresh) else $error("ut high read stale");

	property p_ut_low_fresh;
		s_upd_then_rd(ADR_CH_UT_REF, ADR_UT_REF_LOW)
			|=> reg_rdata_out == $past(meas_data_in[7:0], 2);
	endproperty
	a_ut_low_fresh: assert property (p_ut_low_fresh) else $error("ut low read stale");

	property p_thermal_warning_high_fresh;
		s_upd_then_rd(ADR_CH_THERMAL_WARNING_CUR, ADR_THERMAL_WARNING_CUR_HIGH)
			|=> reg_rdata_out == $past(meas_data_in[15:8], 2);
	endproperty
	a_thermal_warning_high_fresh: assert property (p_thermal_warning_high_fresh) else $error("thermal_warning read stale");
endmodule : adr_readback_bank

// *** dv/tb_top.sv ***
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import adr_pkg::*;

	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [ADR_ADDR_W-1:0] addr = '0;
	logic [ADR_DATA_W-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [ADR_DATA_W-1:0] rdata;
	logic meas_valid = 1'b0;
	adr_chan_t meas_chan = ADR_CH_UT_REF;
	logic [ADR_MEAS_W-1:0] meas_data = '0;
	logic [ADR_NUM_CHAN-1:0] loaded;
	logic wr_ignored;
	logic unmapped;
	int bad_count = 0;
	int total_checks = 0;
	logic [7:0] model [ADR_NUM_REGS];

	adr_readback_bank u_dut (
		.core_clk_in(core_clk),
		.rst_in(rst),
		.reg_addr_in(addr),
		.reg_wdata_in(wdata),
		.reg_wr_in(wr),
		.reg_rd_in(rd),
		.reg_rdata_out(rdata),
		.meas_valid_in(meas_valid),
		.meas_chan_in(meas_chan),
		.meas_data_in(meas_data),
		.loaded_out(loaded),
		.wr_ignored_out(wr_ignored),
		.unmapped_out(unmapped)
	);

	// Free-running 250 MHz clock
	initial begin
		forever #2 core_clk = ~core_clk;
	end

	// Compare seen against expected and count
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %2h seen %2h", what, exp, seen);
		end
	endtask : chk

	// One-cycle read strobe, data checked in the following cycle
	task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp, input logic unm);
		@(posedge core_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge core_clk);
		rd <= 1'b0;
		#1;
		chk("read data", rdata, exp);
		chk("unmapped flag", {7'h00, unmapped}, {7'h00, unm});
	endtask : rd_chk

	// One-cycle write strobe, flags checked in the following cycle
	task automatic wr_chk(input logic [9:0] a, input logic [7:0] d, input logic ign,
			input logic unm);
		@(posedge core_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge core_clk);
		wr <= 1'b0;
		#1;
		chk("write dropped flag", {7'h00, wr_ignored}, {7'h00, ign});
		chk("unmapped flag", {7'h00, unmapped}, {7'h00, unm});
	endtask : wr_chk

	// One converter result strobe
	task automatic meas_load(input logic [2:0] c, input logic [15:0] d);
		@(posedge core_clk);
		meas_valid <= 1'b1;
		meas_chan <= adr_chan_t'(c);
		meas_data <= d;
		@(posedge core_clk);
		meas_valid <= 1'b0;
	endtask : meas_load

	// Print counts and verdict, then stop
	task automatic test_done();
		$display("Checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : test_done

	// Hang guard, far beyond the roughly 150 cycles needed
	initial begin
		#20000;
		bad_count++;
		test_done();
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < ADR_NUM_REGS; i++) begin
			model[i] = (i % 2 == 0) ? 8'h80 : 8'h00;
		end
		for (int i = 0; i < ADR_NUM_REGS; i++) begin
			rd_chk(ADR_UT_REF_HIGH + 10'(i), model[i], 1'b0);
		end
		chk("loaded flags", {3'h0, loaded}, 8'h00);
		$display("Test reset values done");
		for (int i = 0; i < ADR_NUM_REGS; i++) begin
			wr_chk(ADR_UT_REF_HIGH + 10'(i), 8'hFF, 1'b1, 1'b0);
		end
		for (int i = 0; i < ADR_NUM_REGS; i++) begin
			rd_chk(ADR_UT_REF_HIGH + 10'(i), model[i], 1'b0);
		end
		$display("Test writes on reset values done");
		// Channels 0..4 load, code 5 must be dropped
		for (int c = 0; c < 6; c++) begin
			meas_load(3'(c), {8'hC1 + 8'(c), 8'h3C + 8'(c)});
			if (c < 5) begin
				model[2 * c] = 8'hC1 + 8'(c);
			end
			if (c < 4) begin
				model[2 * c + 1] = 8'h3C + 8'(c);
			end
		end
		for (int i = 0; i < ADR_NUM_REGS; i++) begin
			rd_chk(ADR_UT_REF_HIGH + 10'(i), model[i], 1'b0);
		end
		chk("loaded flags", {3'h0, loaded}, 8'h1F);
		$display("Test converter results done");
		for (int i = 0; i < ADR_NUM_REGS; i++) begin
			wr_chk(ADR_UT_REF_HIGH + 10'(i), ~model[i], 1'b1, 1'b0);
		end
		for (int i = 0; i < ADR_NUM_REGS; i++) begin
			rd_chk(ADR_UT_REF_HIGH + 10'(i), model[i], 1'b0);
			rd_chk(ADR_UT_REF_HIGH + 10'(i), model[i], 1'b0);
		end
		$display("Test read-only loaded bank done");
		rd_chk(10'h244, 8'h00, 1'b1);
		rd_chk(10'h24E, 8'h00, 1'b1);
		wr_chk(10'h24E, 8'h55, 1'b0, 1'b1);
		rd_chk(ADR_COMM_SUP_HIGH, model[8], 1'b0);
		$display("Test bank edges done");
		test_done();
	end
endmodule : tb_top
